// ==== cfg_msg_pkg.sv ====
// types, constants and device register map for the configuration message host
// assumes one 100 MHz clock; the device answers on a token stream of its own
package cfg_msg_pkg;
    typedef struct packed {
        logic ctrl;
        logic [7:0] val;
    } tok_s;
    typedef struct packed {
        logic [2:0] kind;
        logic no_reply;
        logic [15:0] node_id;
        logic [7:0] per_id;
        logic [23:0] reply;
        logic [15:0] reg_num;
        logic [31:0] wdata;
        logic [7:0] size;
    } cmd_s;
    typedef struct packed {
        logic busy;
        logic done;
        logic ok;
        logic fail;
        logic bad;
    } stat_s;
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} host_st_e;
    typedef struct packed {
        host_st_e st;
        cmd_s cmd;
        logic [4:0] idx;
        logic txv;
        tok_s tok;
        logic [31:0] dest;
        logic arm;
        stat_s stat;
    } host_s;
    typedef enum logic [1:0] {R_IDLE, R_HEAD, R_DATA, R_TAIL} rx_st_e;
    typedef struct packed {
        rx_st_e st;
        logic [7:0] cnt;
        logic ok;
        logic [31:0] rdata;
        logic done;
        logic rdy;
    } rx_s;
    typedef struct packed {
        cmd_s cmd;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic ready;
        logic [31:0] rdata;
        logic go;
        logic clr;
    } regs_s;
    // message tokens
    localparam logic [7:0] TOK_END = 8'h01, TOK_OK = 8'h03, TOK_FAIL = 8'h04;
    localparam logic [7:0] TOK_WR_CFG = 8'hc0, TOK_RD_CFG = 8'hc1, TOK_WR_PER = 8'h24, TOK_RD_PER = 8'h25;
    localparam logic [15:0] DEST_TILE = 16'hc20c, DEST_NODE = 16'hc30c;
    localparam logic [7:0] DEST_PER = 8'h02, NO_REPLY_LOW = 8'hff, PS_RES_LOW = 8'h0c;
    // kinds: bit 0 read, bit 1 node space, bit 2 analogue peripheral
    localparam logic [2:0] K_PER_RD = 3'h5;
    localparam int KB_RD = 0, KB_NODE = 1, KB_PER = 2;
    localparam logic [7:0] MAX_PER_BYTES = 8'h04, CFG_WORD_BYTES = 8'h04;
    localparam logic [4:0] IX_OPEN = 5'h00, IX_RA_HI = 5'h01, IX_RA_MID = 5'h02, IX_RA_LO = 5'h03;
    localparam logic [4:0] IX_RN_A = 5'h04, IX_RN_B = 5'h05, IX_HDR_END = 5'h06, IX_CFG_WR_END = 5'h0a;
    // software register byte offsets and fields
    localparam logic [7:0] A_CTRL = 8'h00, A_TARGET = 8'h04, A_REPLY = 8'h08, A_REGNUM = 8'h0c;
    localparam logic [7:0] A_WDATA = 8'h10, A_SIZE = 8'h14, A_STATUS = 8'h18, A_RDATA = 8'h1c, A_PSID = 8'h20;
    localparam int CB_GO = 0, CB_KIND = 1, CB_NOREP = 4, TGT_PER = 16, SB_DONE = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;
    // device processor status register map
    localparam logic [7:0] PS_MEM_BASE = 8'h00, PS_VEC_BASE = 8'h01, PS_TILE_CTRL = 8'h02, PS_BOOT = 8'h03;
    localparam logic [7:0] PS_SECURITY = 8'h05, PS_RING_CTRL = 8'h06, PS_RING_CNT0 = 8'h07, PS_RING_CNT1 = 8'h08;
    localparam logic [7:0] PS_RING_CNT2 = 8'h09, PS_RING_CNT3 = 8'h0a, PS_MEM_SIZE = 8'h0c, PS_DBG_SSR = 8'h10;
    localparam logic [7:0] PS_DBG_SPC = 8'h11, PS_DBG_SSP = 8'h12, PS_DBG_FETCH1 = 8'h13, PS_DBG_FETCH2 = 8'h14;
    localparam logic [7:0] PS_DBG_IKIND = 8'h15, PS_DBG_IDATA = 8'h16, PS_DBG_CORE = 8'h18, PS_DBG_SCRATCH = 8'h20;
    localparam logic [7:0] PS_IBP_ADDR = 8'h30, PS_IBP_CTRL = 8'h40, PS_DW_LO = 8'h50, PS_DW_HI = 8'h60;
    localparam logic [7:0] PS_DBP_CTRL = 8'h70, PS_RBP_MASK = 8'h80, PS_RBP_VAL = 8'h90, PS_RBP_CTRL = 8'h9c;
    localparam logic [31:0] RST_MEM_BASE = 32'h00040000;
    localparam int MB_LSB = 2, VB_LSB = 18, TC_TXDLY = 18, TC_TXDIV = 9, TC_RGMII = 8;
    localparam int TC_DYN = 5, TC_DIVEN = 4, TC_UTMI = 2, TC_ULPI = 1;
endpackage

// ==== reply_rx.sv ====
// collects one reply message: ok or fail head, data bytes msb first, closing token
// assumes rx tokens are synchronous to hclk and taken on rx_valid and rx_ready
`timescale 1ns/1ps
module reply_rx (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic arm,
    input wire logic [7:0] nbytes,
    input wire logic rx_valid,
    input wire cfg_msg_pkg::tok_s rx_tok,
    output logic rx_ready,
    output logic done,
    output logic ok,
    output logic [31:0] rdata
);
    cfg_msg_pkg::rx_s q, n;
    logic take;
    logic is_end;

    assign take = rx_valid && q.rdy;
    assign is_end = rx_tok.ctrl && rx_tok.val == cfg_msg_pkg::TOK_END;

    always_comb begin
        n = q;
        n.done = 1'b0;
        case (q.st)
            cfg_msg_pkg::R_IDLE: begin
                if (arm) begin
                    n = '{st: cfg_msg_pkg::R_HEAD, cnt: nbytes, ok: 1'b0, rdata: '0, done: 1'b0, rdy: 1'b1};
                end
            end
            cfg_msg_pkg::R_HEAD: begin
                if (take) begin
                    n.ok = rx_tok.ctrl && rx_tok.val == cfg_msg_pkg::TOK_OK;
                    n.st = (n.ok && q.cnt != '0) ? cfg_msg_pkg::R_DATA : cfg_msg_pkg::R_TAIL;
                end
            end
            cfg_msg_pkg::R_DATA: begin
                if (take && rx_tok.ctrl) begin
                    // short reply counts as failure
                    n.ok = 1'b0;
                    n.st = is_end ? cfg_msg_pkg::R_IDLE : cfg_msg_pkg::R_TAIL;
                    n.rdy = !is_end;
                    n.done = is_end;
                end else if (take) begin
                    n.rdata = {q.rdata[23:0], rx_tok.val};
                    n.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h01) begin
                        n.st = cfg_msg_pkg::R_TAIL;
                    end
                end
            end
            cfg_msg_pkg::R_TAIL: begin
                if (take && is_end) begin
                    n.st = cfg_msg_pkg::R_IDLE;
                    n.rdy = 1'b0;
                    n.done = 1'b1;
                end else if (take) begin
                    n.ok = 1'b0;
                end
            end
            default: n.st = cfg_msg_pkg::R_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rx_ready = q.rdy;
    assign done = q.done;
    assign ok = q.ok;
    assign rdata = q.rdata;
endmodule

// ==== sw_regs.sv ====
// ahb-lite slave holding the command registers and showing host status
// assumes one slave on the bus: hready is this slave's own hreadyout
`timescale 1ns/1ps
module sw_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output cfg_msg_pkg::cmd_s cmd,
    output logic go,
    output logic clr,
    input wire cfg_msg_pkg::stat_s stat,
    input wire logic [31:0] reply_data
);
    cfg_msg_pkg::regs_s q, n;
    logic [31:0] rd_val;

    always_comb begin
        case (q.addr)
            cfg_msg_pkg::A_CTRL: rd_val = 32'({q.cmd.no_reply, q.cmd.kind, 1'b0});
            cfg_msg_pkg::A_TARGET: rd_val = 32'({q.cmd.per_id, q.cmd.node_id});
            cfg_msg_pkg::A_REPLY: rd_val = 32'(q.cmd.reply);
            cfg_msg_pkg::A_REGNUM: rd_val = 32'(q.cmd.reg_num);
            cfg_msg_pkg::A_WDATA: rd_val = q.cmd.wdata;
            cfg_msg_pkg::A_SIZE: rd_val = 32'(q.cmd.size);
            cfg_msg_pkg::A_STATUS: rd_val = 32'({stat.bad, stat.fail, stat.ok, stat.done, stat.busy});
            cfg_msg_pkg::A_RDATA: rd_val = reply_data;
            cfg_msg_pkg::A_PSID: rd_val = 32'({q.cmd.reg_num, cfg_msg_pkg::PS_RES_LOW});
            default: rd_val = '0;
        endcase
    end

    always_comb begin
        n = q;
        n.go = 1'b0;
        n.clr = 1'b0;
        if (q.wr_pend) begin
            n.wr_pend = 1'b0;
            case (q.addr)
                cfg_msg_pkg::A_CTRL: begin
                    n.cmd.kind = hwdata[cfg_msg_pkg::CB_KIND +: 3];
                    n.cmd.no_reply = hwdata[cfg_msg_pkg::CB_NOREP];
                    n.go = hwdata[cfg_msg_pkg::CB_GO];
                end
                cfg_msg_pkg::A_TARGET: begin
                    n.cmd.node_id = hwdata[15:0];
                    n.cmd.per_id = hwdata[cfg_msg_pkg::TGT_PER +: 8];
                end
                cfg_msg_pkg::A_REPLY: n.cmd.reply = hwdata[23:0];
                cfg_msg_pkg::A_REGNUM: n.cmd.reg_num = hwdata[15:0];
                cfg_msg_pkg::A_WDATA: n.cmd.wdata = hwdata;
                cfg_msg_pkg::A_SIZE: n.cmd.size = hwdata[7:0];
                cfg_msg_pkg::A_STATUS: n.clr = hwdata[cfg_msg_pkg::SB_DONE];
                default: n.clr = 1'b0;
            endcase
        end
        if (q.rd_pend) begin
            n.rd_pend = 1'b0;
            n.rdata = rd_val;
            n.ready = 1'b1;
        end
        if (hsel && hready && htrans == cfg_msg_pkg::HTRANS_NONSEQ) begin
            n.addr = haddr[7:0];
            n.wr_pend = hwrite;
            n.rd_pend = !hwrite;
            n.ready = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{default: '0, ready: 1'b1};
        end else begin
            q <= n;
        end
    end

    assign hreadyout = q.ready;
    assign hrdata = q.rdata;
    assign hresp = cfg_msg_pkg::HRESP_OKAY;
    assign cmd = q.cmd;
    assign go = q.go;
    assign clr = q.clr;
endmodule

// ==== msg_host.sv ====
// host that builds configuration request messages and collects the replies
// assumes the token link is synchronous to hclk; software drives it over ahb-lite
// What this block does
// - every request carries a 24-bit reply channel-end address.
// - a write with reply low byte all ones gets no reply.
// - multi-byte fields travel most significant byte first.
// - status register resource id is register number shifted left 8, or 0x0c.
// - tile space destination is tile id above low half 0xc20c.
// - config write is 192, reply address, 16-bit register, 32-bit data, 1.
// - config read is 193, reply address, 16-bit register, 1.
// - node space destination is node id above low half 0xc30c.
// - peripheral destination is node id, peripheral id, low byte 0x02.
// - peripheral write 36, reply, register, count, bytes, 1; read uses 37.
`timescale 1ns/1ps
module msg_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic tx_valid,
    output cfg_msg_pkg::tok_s tx_tok,
    output logic [31:0] tx_dest,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire cfg_msg_pkg::tok_s rx_tok,
    output logic rx_ready
);
    cfg_msg_pkg::host_s q, n;
    cfg_msg_pkg::cmd_s cmd_in;
    logic go;
    logic clr;
    logic rx_done;
    logic rx_ok;
    logic [31:0] rx_data;
    logic [7:0] rx_nbytes;
    logic sent_last;

    function automatic logic is_rd(input cfg_msg_pkg::cmd_s c);
        return c.kind[cfg_msg_pkg::KB_RD];
    endfunction

    function automatic logic is_per(input cfg_msg_pkg::cmd_s c);
        return c.kind[cfg_msg_pkg::KB_PER];
    endfunction

    function automatic logic refused(input cfg_msg_pkg::cmd_s c);
        return c.kind > cfg_msg_pkg::K_PER_RD || (is_per(c) && c.size > cfg_msg_pkg::MAX_PER_BYTES);
    endfunction

    function automatic logic [23:0] reply_of(input cfg_msg_pkg::cmd_s c);
        if (c.no_reply && !is_rd(c)) begin
            return {c.reply[23:8], cfg_msg_pkg::NO_REPLY_LOW};
        end
        return c.reply;
    endfunction

    function automatic logic [4:0] last_idx(input cfg_msg_pkg::cmd_s c);
        if (is_rd(c)) begin
            return cfg_msg_pkg::IX_HDR_END;
        end
        if (is_per(c)) begin
            return cfg_msg_pkg::IX_HDR_END + c.size[4:0];
        end
        return cfg_msg_pkg::IX_CFG_WR_END;
    endfunction

    function automatic logic [7:0] opener(input cfg_msg_pkg::cmd_s c);
        if (is_per(c)) begin
            return is_rd(c) ? cfg_msg_pkg::TOK_RD_PER : cfg_msg_pkg::TOK_WR_PER;
        end
        return is_rd(c) ? cfg_msg_pkg::TOK_RD_CFG : cfg_msg_pkg::TOK_WR_CFG;
    endfunction

    function automatic logic [31:0] dest_of(input cfg_msg_pkg::cmd_s c);
        if (is_per(c)) begin
            return {c.node_id, c.per_id, cfg_msg_pkg::DEST_PER};
        end
        if (c.kind[cfg_msg_pkg::KB_NODE]) begin
            return {c.node_id, cfg_msg_pkg::DEST_NODE};
        end
        return {c.node_id, cfg_msg_pkg::DEST_TILE};
    endfunction

    function automatic cfg_msg_pkg::tok_s tok_at(input cfg_msg_pkg::cmd_s c, input logic [4:0] i);
        logic [23:0] ra;
        logic [4:0] k;
        cfg_msg_pkg::tok_s t;
        ra = reply_of(c);
        k = last_idx(c) - i - 5'h01;
        t.ctrl = 1'b0;
        // data bytes msb first
        t.val = 8'(c.wdata >> {k[1:0], 3'b000});
        if (i == last_idx(c)) begin
            t = '{ctrl: 1'b1, val: cfg_msg_pkg::TOK_END};
        end else if (i == cfg_msg_pkg::IX_OPEN) begin
            t = '{ctrl: 1'b1, val: opener(c)};
        end else if (i == cfg_msg_pkg::IX_RA_HI) begin
            t.val = ra[23:16];
        end else if (i == cfg_msg_pkg::IX_RA_MID) begin
            t.val = ra[15:8];
        end else if (i == cfg_msg_pkg::IX_RA_LO) begin
            t.val = ra[7:0];
        end else if (i == cfg_msg_pkg::IX_RN_A) begin
            t.val = is_per(c) ? c.reg_num[7:0] : c.reg_num[15:8];
        end else if (i == cfg_msg_pkg::IX_RN_B) begin
            t.val = is_per(c) ? c.size : c.reg_num[7:0];
        end
        return t;
    endfunction

    sw_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .cmd(cmd_in),
        .go(go),
        .clr(clr),
        .stat(q.stat),
        .reply_data(rx_data)
    );

    assign rx_nbytes = !is_rd(q.cmd) ? '0 : (is_per(q.cmd) ? q.cmd.size : cfg_msg_pkg::CFG_WORD_BYTES);

    reply_rx u_rx (
        .hclk(hclk),
        .hresetn(hresetn),
        .arm(q.arm),
        .nbytes(rx_nbytes),
        .rx_valid(rx_valid),
        .rx_tok(rx_tok),
        .rx_ready(rx_ready),
        .done(rx_done),
        .ok(rx_ok),
        .rdata(rx_data)
    );

    assign sent_last = q.txv && tx_ready && q.idx == last_idx(q.cmd);

    always_comb begin
        n = q;
        n.arm = 1'b0;
        if (clr) begin
            n.stat.done = 1'b0;
        end
        case (q.st)
            cfg_msg_pkg::H_IDLE: begin
                if (go && refused(cmd_in)) begin
                    n.stat = '{busy: 1'b0, done: 1'b1, ok: 1'b0, fail: 1'b1, bad: 1'b1};
                end else if (go) begin
                    n.cmd = cmd_in;
                    n.stat = '{busy: 1'b1, done: 1'b0, ok: 1'b0, fail: 1'b0, bad: 1'b0};
                    n.idx = '0;
                    n.txv = 1'b1;
                    n.tok = tok_at(cmd_in, '0);
                    n.dest = dest_of(cmd_in);
                    n.st = cfg_msg_pkg::H_SEND;
                end
            end
            cfg_msg_pkg::H_SEND: begin
                if (sent_last) begin
                    n.txv = 1'b0;
                    if (q.cmd.no_reply && !is_rd(q.cmd)) begin
                        // nothing will come back
                        n.stat = '{busy: 1'b0, done: 1'b1, ok: 1'b1, fail: 1'b0, bad: 1'b0};
                        n.st = cfg_msg_pkg::H_IDLE;
                    end else begin
                        n.arm = 1'b1;
                        n.st = cfg_msg_pkg::H_WAIT;
                    end
                end else if (tx_ready) begin
                    n.idx = q.idx + 5'h01;
                    n.tok = tok_at(q.cmd, q.idx + 5'h01);
                end
            end
            cfg_msg_pkg::H_WAIT: begin
                if (rx_done) begin
                    // failure answers also cover rejected registers
                    n.stat = '{busy: 1'b0, done: 1'b1, ok: rx_ok, fail: !rx_ok, bad: 1'b0};
                    n.st = cfg_msg_pkg::H_IDLE;
                end
            end
            default: n.st = cfg_msg_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tx_valid = q.txv;
    assign tx_tok = q.tok;
    assign tx_dest = q.dest;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_tok) && $stable(tx_dest))
        else $error("token changed before it was taken");
    a_open_token: assert property (tx_valid && q.idx == cfg_msg_pkg::IX_OPEN |->
        tx_tok.ctrl && tx_tok.val == opener(q.cmd))
        else $error("wrong opening token");
    a_close_token: assert property (tx_valid && q.idx == last_idx(q.cmd) |->
        tx_tok.ctrl && tx_tok.val == cfg_msg_pkg::TOK_END)
        else $error("wrong closing token");
    a_reply_order: assert property (tx_valid && tx_ready && q.idx == cfg_msg_pkg::IX_RA_HI |=>
        tx_tok.val == q.cmd.reply[15:8] && !tx_tok.ctrl)
        else $error("reply address bytes out of order");
    a_noreply_low: assert property (tx_valid && q.idx == cfg_msg_pkg::IX_RA_LO && q.cmd.no_reply
        && !is_rd(q.cmd) |-> tx_tok.val == cfg_msg_pkg::NO_REPLY_LOW)
        else $error("no-reply write without all-ones low byte");
    a_noreply_done: assert property (sent_last && q.cmd.no_reply && !is_rd(q.cmd) |=>
        q.stat.done && q.stat.ok && !rx_ready [*2])
        else $error("no-reply write waited for an answer");
    a_cfg_word: assert property (tx_valid && tx_ready && !is_per(q.cmd) && !is_rd(q.cmd)
        && q.idx == cfg_msg_pkg::IX_RN_B |=> tx_tok.val == q.cmd.wdata[31:24])
        else $error("data word not msb first");
    a_dest_tile: assert property (q.st != cfg_msg_pkg::H_IDLE && q.cmd.kind[2:1] == 2'b00 |->
        tx_dest == {q.cmd.node_id, cfg_msg_pkg::DEST_TILE})
        else $error("tile destination wrong");
    a_dest_node: assert property (q.st != cfg_msg_pkg::H_IDLE && q.cmd.kind[2:1] == 2'b01 |->
        tx_dest[15:0] == cfg_msg_pkg::DEST_NODE)
        else $error("node destination wrong");
    a_dest_per: assert property (q.st != cfg_msg_pkg::H_IDLE && is_per(q.cmd) |->
        tx_dest == {q.cmd.node_id, q.cmd.per_id, cfg_msg_pkg::DEST_PER})
        else $error("peripheral destination wrong");
    a_reply_result: assert property (q.st == cfg_msg_pkg::H_WAIT && rx_done |=>
        q.stat.done && q.stat.ok == $past(rx_ok) && q.stat.fail != $past(rx_ok))
        else $error("reply result not reported");
    a_wait_armed: assert property (sent_last && !(q.cmd.no_reply && !is_rd(q.cmd)) |=> ##1 rx_ready)
        else $error("reply collector not armed");

    c_tile_write: cover property (q.st == cfg_msg_pkg::H_WAIT && q.cmd.kind == 3'h0 && rx_done && rx_ok);
    c_node_read: cover property (q.st == cfg_msg_pkg::H_WAIT && q.cmd.kind == 3'h3 && rx_done && rx_ok);
    c_per_write: cover property (sent_last && is_per(q.cmd) && !is_rd(q.cmd) && q.cmd.size != '0);
    c_fail_reply: cover property (q.st == cfg_msg_pkg::H_WAIT && rx_done && !rx_ok);
endmodule

// ==== cfg_dev_model.sv ====
// device model: tile, node and peripheral config spaces behind a token link
// assumes tokens move on hclk edges where valid and ready are both high
`timescale 1ns/1ps
module cfg_dev_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic tx_valid,
    input wire cfg_msg_pkg::tok_s tx_tok,
    input wire logic rx_ready,
    output logic tx_ready,
    output logic rx_valid,
    output cfg_msg_pkg::tok_s rx_tok,
    output int n_rep
);
    logic [7:0] q[$];
    cfg_msg_pkg::tok_s rq[$];
    logic [31:0] ps[4];
    logic [31:0] pw;
    task automatic serve();
        logic rd;
        logic ok;
        logic [15:0] rn;
        logic [31:0] d;
        int nb;
        rd = q[0][0];
        rn = {q[4], q[5]};
        d = ps[rn[1:0]];
        nb = 4;
        ok = (rn < 16'h3 || (rn == 16'h3 && rd)) && q.size() == (rd ? 7 : 11);
        if (q[0] == cfg_msg_pkg::TOK_RD_PER || q[0] == cfg_msg_pkg::TOK_WR_PER) begin
            ok = q.size() == (rd ? 7 : 7 + q[5]);
            for (int i = 6; !rd && i < q.size() - 1; i++) pw = {pw[23:0], q[i]};
            d = pw;
            nb = q[5];
        end else if (ok && !rd) begin
            ps[rn[1:0]] = {q[6], q[7], q[8], q[9]} & (rn == 16'h0 ? 32'hfffffffc :
                rn == 16'h1 ? 32'hfffc0000 : 32'h03ffff36);
        end
        if (rd || q[3] != cfg_msg_pkg::NO_REPLY_LOW) begin
            n_rep++;
            rq.push_back({1'b1, ok ? cfg_msg_pkg::TOK_OK : cfg_msg_pkg::TOK_FAIL});
            for (int i = nb - 1; ok && rd && i >= 0; i--) rq.push_back({1'b0, d[8*i +: 8]});
            rq.push_back({1'b1, cfg_msg_pkg::TOK_END});
        end
    endtask
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q.delete();
            rq.delete();
            ps = '{cfg_msg_pkg::RST_MEM_BASE, 32'h0, 32'h0, 32'h0};
            pw = 32'ha1a2a3a4;
            n_rep = 0;
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_tok <= '0;
        end else begin
            tx_ready <= slow ? !tx_ready : 1'b1;
            if (rx_valid && rx_ready)
                void'(rq.pop_front());
            if (tx_valid && tx_ready) begin
                q.push_back(tx_tok.val);
                if (tx_tok.ctrl && tx_tok.val == cfg_msg_pkg::TOK_END) begin
                    serve();
                    q.delete();
                end
            end
            rx_valid <= rq.size() != 0;
            rx_tok <= rq.size() != 0 ? rq[0] : ~rx_tok;
        end
    end
endmodule

// ==== msg_host_tb_top.sv ====
// self-checking bench for msg_host against the token device model
// assumes one 100 MHz clock and a single ahb-lite slave
`timescale 1ns/1ps
module msg_host_tb_top;
    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] rn;
        logic [31:0] wd;
        logic [7:0] sz;
        logic [4:0] st;
        logic [31:0] rd;
    } row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic slow = 1'b0;
    logic hreadyout, hresp, tx_valid, tx_ready, rx_valid, rx_ready;
    logic [31:0] hrdata, tx_dest, dest_seen, v, st;
    cfg_msg_pkg::tok_s tx_tok, rx_tok;
    int fail_count = 0, n_checks = 0, n_rep, n0;
    row_s rows[11] = '{'{3'h1, 16'h0, 32'h0, 8'h0, 5'h6, 32'h00040000},
        '{3'h0, 16'h0, 32'hffffffff, 8'h0, 5'h6, 32'h0}, '{3'h1, 16'h0, 32'h0, 8'h0, 5'h6, 32'hfffffffc},
        '{3'h2, 16'h2, 32'hffffffff, 8'h0, 5'h6, 32'h0}, '{3'h3, 16'h2, 32'h0, 8'h0, 5'h6, 32'h03ffff36},
        '{3'h0, 16'h1, 32'hffffffff, 8'h0, 5'h6, 32'h0}, '{3'h1, 16'h1, 32'h0, 8'h0, 5'h6, 32'hfffc0000},
        '{3'h0, 16'h3, 32'h1, 8'h0, 5'ha, 32'h0}, '{3'h3, 16'h40, 32'h0, 8'h0, 5'ha, 32'h0},
        '{3'h5, 16'h4, 32'h0, 8'h4, 5'h6, 32'ha1a2a3a4}, '{3'h4, 16'h7, 32'h55aa, 8'h2, 5'h6, 32'h0}};
    msg_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .tx_valid(tx_valid), .tx_tok(tx_tok), .tx_dest(tx_dest), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_tok(rx_tok), .rx_ready(rx_ready));
    cfg_dev_model dev (.hclk(hclk), .hresetn(hresetn), .slow(slow), .tx_valid(tx_valid), .tx_tok(tx_tok),
        .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_tok(rx_tok), .n_rep(n_rep));
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (tx_valid && tx_ready) dest_seen <= tx_dest;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        logic r;
        w = 0;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= cfg_msg_pkg::HTRANS_NONSEQ;
        // ready and data are sampled as they stand just before the edge
        do begin
            @(negedge hclk);
            r = hreadyout;
            @(posedge hclk);
        end while (r !== 1'b1 && ++w < 50);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(negedge hclk);
            r = hreadyout;
            v = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1 && ++w < 50);
        if (w >= 50) fail_count++;
    endtask
    task automatic run(input logic [2:0] k, input logic nr, input logic [15:0] rn, input logic [31:0] wd,
        input logic [7:0] sz);
        int w;
        w = 0;
        bus(1'b1, cfg_msg_pkg::A_TARGET, 32'h005a1234);
        bus(1'b1, cfg_msg_pkg::A_REPLY, 32'h00abcd07);
        bus(1'b1, cfg_msg_pkg::A_REGNUM, {16'h0, rn});
        bus(1'b1, cfg_msg_pkg::A_WDATA, wd);
        bus(1'b1, cfg_msg_pkg::A_SIZE, {24'h0, sz});
        bus(1'b1, cfg_msg_pkg::A_CTRL, {27'h0, nr, k, 1'b1});
        do bus(1'b0, cfg_msg_pkg::A_STATUS, 32'h0); while (v[1] !== 1'b1 && ++w < 300);
        if (w >= 300) fail_count++;
        st = v & 32'h1f;
        bus(1'b1, cfg_msg_pkg::A_STATUS, 32'h2);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        chk({28'h0, hresp, hreadyout, tx_valid, rx_ready}, 32'h4);
        chk(hrdata, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 11; i++) begin
            slow <= i[0];
            run(rows[i].kind, 1'b0, rows[i].rn, rows[i].wd, rows[i].sz);
            chk(st, {27'h0, rows[i].st});
            chk(dest_seen, rows[i].kind[2] ? 32'h12345a02 : {16'h1234, rows[i].kind[1] ?
                cfg_msg_pkg::DEST_NODE : cfg_msg_pkg::DEST_TILE});
            if (rows[i].st == 5'h6 && rows[i].kind[0]) begin
                bus(1'b0, cfg_msg_pkg::A_RDATA, 32'h0);
                chk(v, rows[i].rd);
            end
            $display("row %0d done", i);
        end
        n0 = n_rep;
        run(3'h0, 1'b1, 16'h0, 32'h12345678, 8'h0);
        chk(st, 32'h6);
        chk(n_rep - n0, 0);
        run(3'h1, 1'b0, 16'h0, 32'h0, 8'h0);
        bus(1'b0, cfg_msg_pkg::A_RDATA, 32'h0);
        chk(v, 32'h12345678);
        run(3'h6, 1'b0, 16'h0, 32'h0, 8'h0);
        chk(st, 32'h1a);
        run(3'h5, 1'b0, 16'h0, 32'h0, 8'h5);
        chk(st, 32'h1a);
        bus(1'b1, cfg_msg_pkg::A_REGNUM, 32'h2);
        bus(1'b0, cfg_msg_pkg::A_PSID, 32'h0);
        chk(v, 32'h20c);
        bus(1'b0, 8'h3c, 32'h0);
        chk(v, 32'h0);
        run(3'h5, 1'b0, 16'h4, 32'h0, 8'h2);
        chk(st, 32'h6);
        bus(1'b0, cfg_msg_pkg::A_RDATA, 32'h0);
        chk(v, 32'h55aa);
        // reset in the middle of a message
        bus(1'b1, cfg_msg_pkg::A_CTRL, 32'h3);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({28'h0, hresp, hreadyout, tx_valid, rx_ready}, 32'h4);
        hresetn <= 1'b1;
        @(posedge hclk);
        run(3'h1, 1'b0, 16'h0, 32'h0, 8'h0);
        bus(1'b0, cfg_msg_pkg::A_RDATA, 32'h0);
        chk(v, 32'h00040000);
        $display("awkward cases done");
        test_done();
    end
    initial begin
        #200us;
        fail_count++;
        test_done();
    end
endmodule
